/* common/mwc_pkg.sv */
// memory window and wait-state control: shared constants
// assumes a 32-bit APB register port and a 16-bit data/program address
package mwc_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_WIN_CFG = 8'h0b;
   localparam logic [7:0] IDX_PROG_WAIT = 8'h0c;
   localparam logic [7:0] IDX_DATA_WAIT = 8'h0d;
   localparam logic [7:0] IDX_PERIPH_CTL = 8'h15;
   localparam logic [11:0] ADDR_WIN_CFG = {2'h0, IDX_WIN_CFG, 2'h0};
   localparam logic [11:0] ADDR_PROG_WAIT = {2'h0, IDX_PROG_WAIT, 2'h0};
   localparam logic [11:0] ADDR_DATA_WAIT = {2'h0, IDX_DATA_WAIT, 2'h0};
   localparam logic [11:0] ADDR_PERIPH_CTL = {2'h0, IDX_PERIPH_CTL, 2'h0};

   // reset values
   localparam logic [7:0] RST_WIN_CFG = 8'h00;
   localparam logic [7:0] RST_PROG_WAIT = 8'h8b;
   localparam logic [7:0] RST_DATA_WAIT = 8'hff;
   localparam logic [7:0] RST_PERIPH_CTL = 8'h8c;

   // field positions
   localparam int WIN_START_LSB = 0;
   localparam int WIN_END_LSB = 6;
   localparam int PROG_CNT_LSB = 0;
   localparam int PROG_INT_BIT = 2;
   localparam int DATA_LOW_LSB = 0;
   localparam int DATA_HIGH_LSB = 4;
   localparam int PERIPH_WAIT_EN_BIT = 6;
   localparam logic [7:0] PROG_WAIT_ONES = 8'h88;
   localparam logic [7:0] DATA_WAIT_ONES = 8'h88;
   localparam logic [7:0] WIN_CFG_FIXED_ONES = 8'h30;

   // window timing and built-in external data cycles
   localparam logic [4:0] WIN_EXTRA_BYTE = 5'h03;
   localparam logic [4:0] WIN_EXTRA_WORD = 5'h06;
   localparam logic [4:0] EXT_BUILTIN_BYTE = 5'h02;

   // window end addresses selected by bits 7:6
   localparam logic [15:0] WIN_END_0 = 16'h3fff;
   localparam logic [15:0] WIN_END_1 = 16'h7fff;
   localparam logic [15:0] WIN_END_2 = 16'hbfff;
   localparam logic [15:0] WIN_END_3 = 16'hffff;

   typedef enum logic {MWC_IDLE, MWC_BUSY} mwc_state_t;
endpackage : mwc_pkg

/* logic/mwc_top.sv */
// memory window and wait-state control, APB registers plus access sequencer
// assumes the CPU presents one access at a time and waits for ACC_DONE
//
// Summary of operation
// RULE_01: window reads return program segment bytes
// RULE_02: window read adds 3 byte, 6 word
// RULE_03: window write gets no extra cycles
// RULE_04: config low nibble start, high nibble end
// RULE_05: zero start nibble disables the window
// RULE_06: internal RAM wins over the window
// RULE_07: window range never reaches external bus
// RULE_08: software keeps start above reserved area
// RULE_09: bits 7:6 pick the end address
// RULE_10: window inactive after reset until configured
// RULE_11: window config accepts first write only
// RULE_12: software keeps start not above end
// RULE_13: program wait 0-3, optional internal apply
// RULE_14: program wait bits 3,7 one, 4-6 zero
// RULE_15: program wait resets to 8bH
// RULE_16: data wait per half of space
// RULE_17: data wait resets to ffH
// RULE_18: external data adds built-in plus programmed
// RULE_19: wait pin high stretches data strobes
// RULE_20: wait ends after two low samples
// RULE_21: longer of programmed and pin waits
// RULE_22: wait pin only with enable, data only
// RULE_23: one wait cycle is one clock
`timescale 1ns/1ps
module mwc_top
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_B,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // cpu access request
   input wire logic ACC_REQ,
   input wire logic ACC_WRITE,
   input wire logic ACC_WORD,
   input wire logic ACC_PROG,
   input wire logic ACC_INTERNAL,
   input wire logic [15:0] ACC_ADDR,
   input wire logic [3:0] SEGMENT_SELECTOR,
   // cpu access answer
   output logic ACC_DONE,
   output logic ACC_TO_WINDOW,
   output logic ACC_TO_EXT,
   output logic [3:0] WINDOW_SEGMENT,
   // external memory strobes and wait pin
   output logic EXT_RD_B,
   output logic EXT_WR_B,
   input wire logic EXTERNAL_WAIT_PIN
);
   logic [7:0] win_cfg_reg;
   logic win_written_reg;
   logic [7:0] prog_wait_reg;
   logic [7:0] data_wait_reg;
   logic [7:0] periph_ctl_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   mwc_pkg::mwc_state_t state_reg;
   logic [4:0] cnt_reg;
   logic ext_data_reg;
   logic ext_hold_reg;
   logic pin_prev_reg;
   logic done_reg;
   logic to_win_reg;
   logic to_ext_reg;
   logic [3:0] seg_reg;
   logic rd_b_reg;
   logic wr_b_reg;

   logic apb_access;
   logic apb_commit;
   logic addr_hit;
   logic [7:0] rd_byte;
   logic [3:0] win_start;
   logic [15:0] win_end;
   logic win_enabled;
   logic in_window;
   logic [4:0] prog_waits;
   logic [4:0] data_waits;
   logic [4:0] extra_next;
   logic is_win_read;
   logic is_ext_data;
   logic hold_next;
   logic acc_take;
   logic acc_finish;

   assign apb_access = PSEL && PENABLE && !pready_reg;
   assign apb_commit = PSEL && PENABLE && pready_reg;

   always_comb
   begin
      addr_hit = 1'b1;
      case (PADDR)
         mwc_pkg::ADDR_WIN_CFG: rd_byte = win_cfg_reg;
         mwc_pkg::ADDR_PROG_WAIT: rd_byte = prog_wait_reg;
         mwc_pkg::ADDR_DATA_WAIT: rd_byte = data_wait_reg;
         mwc_pkg::ADDR_PERIPH_CTL: rd_byte = periph_ctl_reg;
         default:
         begin
            rd_byte = 8'h00;
            addr_hit = 1'b0;
         end
      endcase
   end

   // one wait state on every transfer keeps the answer registered
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         pready_reg <= 1'b0;
      else
         pready_reg <= apb_access;
   end

   // unmapped offsets answer with an error and change nothing
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         pslverr_reg <= 1'b0;
      else
         pslverr_reg <= apb_access && !addr_hit;
   end

   // read data is zero outside the answer cycle
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         prdata_reg <= 32'h0000_0000;
      else
         prdata_reg <= (apb_access && !PWRITE) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
   end

   // RULE_11: first write only
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
      begin
         win_cfg_reg <= mwc_pkg::RST_WIN_CFG;
         win_written_reg <= 1'b0;
      end
      else if (apb_commit && PWRITE && PADDR == mwc_pkg::ADDR_WIN_CFG && !win_written_reg)
      begin
         // RULE_04: bits 5:4 kept as written
         win_cfg_reg <= PWDATA[7:0];
         win_written_reg <= 1'b1;
      end
   end

   // RULE_15: reset to 8bH
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         prog_wait_reg <= mwc_pkg::RST_PROG_WAIT;
      else if (apb_commit && PWRITE && PADDR == mwc_pkg::ADDR_PROG_WAIT)
         // RULE_14: fixed ones and zeros
         prog_wait_reg <= mwc_pkg::PROG_WAIT_ONES | {5'h00, PWDATA[2:0]};
   end

   // RULE_17: reset to ffH
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         data_wait_reg <= mwc_pkg::RST_DATA_WAIT;
      else if (apb_commit && PWRITE && PADDR == mwc_pkg::ADDR_DATA_WAIT)
         // RULE_16: bits 3 and 7 read one
         data_wait_reg <= mwc_pkg::DATA_WAIT_ONES | {1'b0, PWDATA[6:4], 1'b0, PWDATA[2:0]};
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         periph_ctl_reg <= mwc_pkg::RST_PERIPH_CTL;
      else if (apb_commit && PWRITE && PADDR == mwc_pkg::ADDR_PERIPH_CTL)
         periph_ctl_reg <= PWDATA[7:0];
   end

   assign win_start = win_cfg_reg[mwc_pkg::WIN_START_LSB +: 4];

   // RULE_09: end address select
   always_comb
   begin
      case (win_cfg_reg[mwc_pkg::WIN_END_LSB +: 2])
         2'h0: win_end = mwc_pkg::WIN_END_0;
         2'h1: win_end = mwc_pkg::WIN_END_1;
         2'h2: win_end = mwc_pkg::WIN_END_2;
         default: win_end = mwc_pkg::WIN_END_3;
      endcase
   end

   // RULE_10: inactive until written
   // RULE_05: zero start disables
   assign win_enabled = win_written_reg && (win_start != 4'h0);
   // start not above end is left to software, no ordering check here
   assign in_window = win_enabled && (ACC_ADDR[15:12] >= win_start) && (ACC_ADDR <= win_end);

   // RULE_06: internal RAM has priority
   // RULE_01: data read redirected
   assign is_win_read = !ACC_PROG && !ACC_WRITE && !ACC_INTERNAL && in_window;
   // RULE_07: window range kept off the bus
   assign is_ext_data = !ACC_PROG && !ACC_INTERNAL && !in_window;

   // RULE_13: program fetch waits
   assign prog_waits = (!ACC_INTERNAL || prog_wait_reg[mwc_pkg::PROG_INT_BIT])
      ? {3'h0, prog_wait_reg[mwc_pkg::PROG_CNT_LSB +: 2]} : 5'h00;

   // RULE_16: area chosen by address bit 15
   // RULE_18: built-in per byte plus programmed once
   assign data_waits = (ACC_ADDR[15] ? {2'h0, data_wait_reg[mwc_pkg::DATA_HIGH_LSB +: 3]}
      : {2'h0, data_wait_reg[mwc_pkg::DATA_LOW_LSB +: 3]}) + mwc_pkg::EXT_BUILTIN_BYTE
      + (ACC_WORD ? mwc_pkg::EXT_BUILTIN_BYTE : 5'h00);

   always_comb
   begin
      if (ACC_PROG)
         extra_next = prog_waits;
      // RULE_02: window read penalty
      else if (is_win_read)
         extra_next = ACC_WORD ? mwc_pkg::WIN_EXTRA_WORD : mwc_pkg::WIN_EXTRA_BYTE;
      else if (is_ext_data)
         extra_next = data_waits;
      // RULE_03: window write adds nothing
      else
         extra_next = 5'h00;
   end

   // RULE_22: enable bit and data space only
   // RULE_19: high sample holds the strobe
   // RULE_20: two low samples release
   always_comb
   begin
      hold_next = 1'b0;
      if (state_reg == mwc_pkg::MWC_BUSY && ext_data_reg && periph_ctl_reg[mwc_pkg::PERIPH_WAIT_EN_BIT])
      begin
         if (EXTERNAL_WAIT_PIN)
            hold_next = 1'b1;
         else if (ext_hold_reg && pin_prev_reg)
            hold_next = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         ext_hold_reg <= 1'b0;
      else
         ext_hold_reg <= hold_next;
   end

   // previous pin sample, the first of the two low samples
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         pin_prev_reg <= 1'b0;
      else
         pin_prev_reg <= EXTERNAL_WAIT_PIN;
   end

   // a request is taken only while idle; later pulses are ignored
   assign acc_take = (state_reg == mwc_pkg::MWC_IDLE) && ACC_REQ;
   // RULE_21: ends when both waits are done
   assign acc_finish = (state_reg == mwc_pkg::MWC_BUSY) && (cnt_reg == 5'h00) && !ext_hold_reg;

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         state_reg <= mwc_pkg::MWC_IDLE;
      else
      begin
         case (state_reg)
            mwc_pkg::MWC_IDLE:
            begin
               if (acc_take)
                  state_reg <= mwc_pkg::MWC_BUSY;
            end
            mwc_pkg::MWC_BUSY:
            begin
               if (acc_finish)
                  state_reg <= mwc_pkg::MWC_IDLE;
            end
            default:
               state_reg <= mwc_pkg::MWC_IDLE;
         endcase
      end
   end

   // RULE_23: counted in clock cycles
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         cnt_reg <= 5'h00;
      else if (acc_take)
         cnt_reg <= extra_next;
      else if (state_reg == mwc_pkg::MWC_BUSY && cnt_reg != 5'h00)
         cnt_reg <= cnt_reg - 5'h01;
   end

   // the wait pin only acts on external data accesses
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         ext_data_reg <= 1'b0;
      else if (acc_take)
         ext_data_reg <= is_ext_data;
   end

   // routing of the access, held until the next request
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
      begin
         to_win_reg <= 1'b0;
         to_ext_reg <= 1'b0;
      end
      else if (acc_take)
      begin
         to_win_reg <= is_win_read;
         to_ext_reg <= is_ext_data || (ACC_PROG && !ACC_INTERNAL);
      end
   end

   // segment latched at the request, so a later selector change cannot move a read in flight
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         seg_reg <= 4'h0;
      else if (acc_take)
         seg_reg <= SEGMENT_SELECTOR;
   end

   // one-cycle answer pulse
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         done_reg <= 1'b0;
      else
         done_reg <= acc_finish;
   end

   // strobes fall at the take edge and rise with the answer pulse
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
      begin
         rd_b_reg <= 1'b1;
         wr_b_reg <= 1'b1;
      end
      else if (acc_take)
      begin
         rd_b_reg <= !(is_ext_data && !ACC_WRITE);
         wr_b_reg <= !(is_ext_data && ACC_WRITE);
      end
      else if (acc_finish)
      begin
         rd_b_reg <= 1'b1;
         wr_b_reg <= 1'b1;
      end
   end

   assign PRDATA = prdata_reg;
   assign PREADY = pready_reg;
   assign PSLVERR = pslverr_reg;
   assign ACC_DONE = done_reg;
   assign ACC_TO_WINDOW = to_win_reg;
   assign ACC_TO_EXT = to_ext_reg;
   assign WINDOW_SEGMENT = seg_reg;
   assign EXT_RD_B = rd_b_reg;
   assign EXT_WR_B = wr_b_reg;
endmodule : mwc_top

/* test/mwc_sva.sv */
// checker for mwc_top: access latency, window and register read rules
// assumes the bench never requests an access while one is pending
`timescale 1ns/1ps
module mwc_sva
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_B,
   // apb
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   // access
   input wire logic ACC_REQ,
   input wire logic ACC_WRITE,
   input wire logic ACC_WORD,
   input wire logic ACC_PROG,
   input wire logic ACC_INTERNAL,
   input wire logic ACC_DONE,
   input wire logic ACC_TO_WINDOW,
   input wire logic ACC_TO_EXT,
   input wire logic EXT_RD_B,
   input wire logic EXT_WR_B,
   input wire logic EXTERNAL_WAIT_PIN
);
   logic busy_reg;
   logic win_wr_reg;
   logic win_on_reg;
   logic pin_en_reg;
   logic wr_ok;
   assign wr_ok = PSEL && PENABLE && PREADY && PWRITE;
   always_ff @(posedge SYS_CLK)
      if (!RST_B || ACC_DONE)
         busy_reg <= 1'b0;
      else if (ACC_REQ)
         busy_reg <= 1'b1;
   // later config writes must not move the window
   always_ff @(posedge SYS_CLK)
      if (!RST_B)
      begin
         win_wr_reg <= 1'b0;
         win_on_reg <= 1'b0;
      end
      else if (wr_ok && PADDR == mwc_pkg::ADDR_WIN_CFG && !win_wr_reg)
      begin
         win_wr_reg <= 1'b1;
         win_on_reg <= PWDATA[3:0] != 4'h0;
      end
   always_ff @(posedge SYS_CLK)
      if (!RST_B)
         pin_en_reg <= 1'b0;
      else if (wr_ok && PADDR == mwc_pkg::ADDR_PERIPH_CTL)
         pin_en_reg <= PWDATA[6];
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_B);
   sequence s_take;
      ACC_REQ && !busy_reg;
   endsequence
   sequence s_win_rd(w);
      s_take ##0 (!ACC_WRITE && ACC_WORD == w) ##1 ACC_TO_WINDOW;
   endsequence
   AST_WIN_BYTE: assert property (s_win_rd(1'b0) |-> !ACC_DONE[*4] ##1 ACC_DONE)
      else $error("window byte latency");
   AST_WIN_WORD: assert property (s_win_rd(1'b1) |-> !ACC_DONE[*7] ##1 ACC_DONE)
      else $error("window word latency");
   AST_EXT_MIN: assert property ((s_take ##0 !(ACC_INTERNAL || ACC_PROG) ##1 ACC_TO_EXT) |-> !ACC_DONE[*3])
      else $error("external access too short");
   AST_INT_RAM: assert property (s_take ##0 (ACC_INTERNAL && !ACC_PROG) |=> !ACC_DONE ##1 (ACC_DONE && !ACC_TO_WINDOW))
      else $error("internal ram access wrong");
   AST_WIN_OFF: assert property (!win_on_reg |-> !ACC_TO_WINDOW)
      else $error("window used while off");
   AST_NO_EXT: assert property (ACC_TO_WINDOW |-> EXT_RD_B && EXT_WR_B)
      else $error("window access strobed");
   AST_RD_STROBE: assert property ((s_take ##0 !(ACC_WRITE || ACC_INTERNAL || ACC_PROG) ##1 ACC_TO_EXT) |-> !EXT_RD_B && EXT_WR_B)
      else $error("external read strobe wrong");
   AST_PIN_HOLD: assert property (pin_en_reg && !(EXT_RD_B && EXT_WR_B) && EXTERNAL_WAIT_PIN |=> !ACC_DONE[*2])
      else $error("ended with wait pin high");
   AST_PROG_BITS: assert property (PREADY && !PWRITE && PADDR == mwc_pkg::ADDR_PROG_WAIT |-> PRDATA[7:3] == 5'h11)
      else $error("program wait fixed bits");
endmodule : mwc_sva
bind mwc_top mwc_sva u_sva (.SYS_CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
   .ACC_REQ, .ACC_WRITE, .ACC_WORD, .ACC_PROG, .ACC_INTERNAL, .ACC_DONE, .ACC_TO_WINDOW, .ACC_TO_EXT,
   .EXT_RD_B, .EXT_WR_B, .EXTERNAL_WAIT_PIN);

/* test/mwc_ext_dev.sv */
// slow external data device that drives the wait pin
// assumes hold_n is set before the access starts
`timescale 1ns/1ps
module mwc_ext_dev
(
   // clock and strobes
   input wire logic clk,
   input wire logic rd_b,
   input wire logic wr_b,
   // hold length in cycles
   input wire logic [3:0] hold_n,
   // wait pin
   output logic wait_pin
);
   logic [3:0] cnt_reg;
   always_ff @(posedge clk)
      cnt_reg <= (rd_b && wr_b) ? 4'h0 : cnt_reg + 4'h1;
   always_ff @(posedge clk)
      wait_pin <= !(rd_b && wr_b) && cnt_reg < hold_n;
endmodule : mwc_ext_dev

/* test/tb.sv */
// bench for mwc_top: apb register tasks and access timing scenarios
// assumes mwc_sva is bound in and mwc_ext_dev drives the wait pin
`timescale 1ns/1ps
module tb;
   logic SYS_CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic PREADY, PSLVERR, ACC_DONE, ACC_TO_WINDOW, ACC_TO_EXT, EXT_RD_B, EXT_WR_B, EXTERNAL_WAIT_PIN, er, strb;
   logic ACC_REQ = 1'b0, ACC_WRITE = 1'b0, ACC_WORD = 1'b0, ACC_PROG = 1'b0, ACC_INTERNAL = 1'b0;
   logic [15:0] ACC_ADDR = 16'h0;
   logic [3:0] SEGMENT_SELECTOR = 4'h0, WINDOW_SEGMENT, hold_n = 4'h0;
   int n_fail = 0, checks_done = 0, k;
   always #25 SYS_CLK = ~SYS_CLK;
   mwc_top dut (.SYS_CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
      .ACC_REQ, .ACC_WRITE, .ACC_WORD, .ACC_PROG, .ACC_INTERNAL, .ACC_ADDR, .SEGMENT_SELECTOR, .ACC_DONE,
      .ACC_TO_WINDOW, .ACC_TO_EXT, .WINDOW_SEGMENT, .EXT_RD_B, .EXT_WR_B, .EXTERNAL_WAIT_PIN);
   mwc_ext_dev ext (.clk(SYS_CLK), .rd_b(EXT_RD_B), .wr_b(EXT_WR_B), .hold_n(hold_n), .wait_pin(EXTERNAL_WAIT_PIN));
   task automatic conclude;
      if (n_fail == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic lim(input int n);
      if (n >= 40)
      begin
         n_fail++;
         conclude;
      end
   endtask : lim
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge SYS_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      n = 0;
      do
      begin
         @(posedge SYS_CLK);
         n++;
      end
      while (PREADY !== 1'b1 && n < 40);
      lim(n);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("reg", e, rd);
   endtask : rdc
   // k counts cycles from the request cycle to the done cycle
   task automatic acc(input logic [3:0] f, input logic [15:0] a);
      @(posedge SYS_CLK);
      {ACC_WRITE, ACC_WORD, ACC_PROG, ACC_INTERNAL} <= f;
      ACC_ADDR <= a;
      ACC_REQ <= 1'b1;
      @(posedge SYS_CLK);
      ACC_REQ <= 1'b0;
      k = 0;
      strb = 1'b0;
      do
      begin
         @(posedge SYS_CLK);
         k++;
         if (EXT_RD_B !== 1'b1 || EXT_WR_B !== 1'b1)
            strb = 1'b1;
      end
      while (ACC_DONE !== 1'b1 && k < 40);
      lim(k);
   endtask : acc
   task automatic ac(input logic [3:0] f, input logic [15:0] a, input logic [31:0] e);
      acc(f, a);
      chk("cycles", e, 32'(k));
   endtask : ac
   task automatic reset_dut;
      RST_B <= 1'b0;
      repeat (10) @(posedge SYS_CLK);
      RST_B <= 1'b1;
   endtask : reset_dut
   task automatic t_regs;
      rdc(mwc_pkg::ADDR_PROG_WAIT, 32'h8b);
      rdc(mwc_pkg::ADDR_DATA_WAIT, 32'hff);
      rdc(mwc_pkg::ADDR_PERIPH_CTL, 32'h8c);
      apb(1'b0, 12'h040, 32'h0);
      chk("slverr", 32'h1, {31'h0, er});
      ac(4'h0, 16'h2000, 32'd11);
      chk("route", 32'h3, {30'h0, ACC_TO_EXT, strb});
      ac(4'h2, 16'h0100, 32'd5);
      chk("route", 32'h2, {30'h0, ACC_TO_EXT, strb});
      ac(4'h3, 16'h0100, 32'd2);
      chk("route", 32'h0, {30'h0, ACC_TO_EXT, strb});
   endtask : t_regs
   task automatic t_waits;
      apb(1'b1, mwc_pkg::ADDR_PROG_WAIT, 32'h05);
      rdc(mwc_pkg::ADDR_PROG_WAIT, 32'h8d);
      apb(1'b1, mwc_pkg::ADDR_DATA_WAIT, 32'h30);
      rdc(mwc_pkg::ADDR_DATA_WAIT, 32'hb8);
      ac(4'h3, 16'h0100, 32'd3);
      ac(4'h0, 16'h7fff, 32'd4);
      ac(4'h0, 16'h8000, 32'd7);
      ac(4'h4, 16'h2000, 32'd6);
   endtask : t_waits
   task automatic t_pin;
      hold_n <= 4'h6;
      ac(4'h0, 16'h2000, 32'd4);
      apb(1'b1, mwc_pkg::ADDR_PERIPH_CTL, 32'hcc);
      acc(4'h0, 16'h2000);
      chk("held", 32'h1, {31'h0, k >= 10});
      acc(4'h8, 16'h2000);
      chk("held", 32'h1, {31'h0, k >= 10});
      apb(1'b1, mwc_pkg::ADDR_DATA_WAIT, 32'h77);
      hold_n <= 4'h1;
      ac(4'h0, 16'h2000, 32'd11);
   endtask : t_pin
   task automatic t_ends;
      logic [15:0] e;
      for (int i = 0; i < 4; i++)
      begin
         reset_dut;
         e = {2'(i), 14'h3fff};
         SEGMENT_SELECTOR <= 4'(i + 5);
         apb(1'b1, mwc_pkg::ADDR_WIN_CFG, {24'h0, 2'(i), 6'h31});
         ac(4'h0, e, 32'd5);
         chk("win", {27'h0, 1'b1, 4'(i + 5)}, {27'h0, ACC_TO_WINDOW, WINDOW_SEGMENT});
         if (i < 3)
            ac(4'h0, e + 16'h1, 32'd11);
      end
   endtask : t_ends
   task automatic t_win;
      apb(1'b1, mwc_pkg::ADDR_WIN_CFG, 32'h71);
      rdc(mwc_pkg::ADDR_WIN_CFG, 32'hf1);
      ac(4'h4, 16'h1000, 32'd8);
      ac(4'h1, 16'h2000, 32'd2);
      ac(4'h8, 16'h2000, 32'd2);
      chk("strobe", 32'h0, {31'h0, strb});
      chk("route", 32'h0, {30'h0, ACC_TO_EXT, ACC_TO_WINDOW});
      ac(4'h0, 16'h0fff, 32'd11);
      reset_dut;
      apb(1'b1, mwc_pkg::ADDR_WIN_CFG, 32'h70);
      ac(4'h0, 16'h2000, 32'd11);
   endtask : t_win
   initial
   begin
      reset_dut;
      t_regs;
      t_waits;
      t_pin;
      t_ends;
      t_win;
      conclude;
   end
endmodule : tb
